// >>> pasm_consts.svh
`ifndef PASM_CONSTS_SVH
`define PASM_CONSTS_SVH

// ****************************************************************
// address map
// ****************************************************************
`define PASM_ADDR_W          32
`define PASM_TOP_BIT         31
`define PASM_SEG_USER_MSB    1'B0
`define PASM_SEG_CACHED      3'H4
`define PASM_SEG_UNCACHED    3'H5
`define PASM_SEG_UPPER       2'H3
`define PASM_USER_OFFSET     32'H4000_0000
`define PASM_LOW_MASK        32'H1FFF_FFFF
`define PASM_TOP_CLEAR       32'H7FFF_FFFF
`define PASM_RESET_VECTOR    32'HBFC0_0000
`define PASM_RESET_PHYS      32'H1FC0_0000
`define PASM_UPPER_LIMIT     32'HFEFF_FFFF
`define PASM_GAP_LO          32'H2000_0000
`define PASM_GAP_HI          32'H3FFF_FFFF

`endif

// >>> pasm_map.sv
`timescale 1ns/100ps
`include "pasm_consts.svh"

module pasm_map
  import pasm_pkg::*;
#(
  parameter bit HAS_XLAT         = 1'b0,
  parameter bit HAS_RESERVED_TOP = 1'b0
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic [31:0]             prog_addr,
  input  wire logic                    req_valid,
  input  wire logic                    mode_to_user,
  input  wire logic                    mode_to_kernel,
  input  wire logic                    insn_privileged,
  input  wire logic                    insn_coproc_access,
  input  wire logic                    coproc_user_enable,
  input  wire logic [31:0]             xlat_phys_addr,
  input  wire logic                    xlat_cacheable,
  input  wire logic                    xlat_fault,
  output logic                         user_mode,
  output logic [31:0]                  reset_fetch_addr,
  output logic [31:0]                  phys_addr,
  output logic                         cacheable,
  output logic                         addr_error,
  output logic                         insn_illegal,
  output logic                         mem_req,
  output logic                         xlat_req,
  output pasm_pkg::pasm_seg_t          seg
);
  import pasm_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial begin
    if (`PASM_ADDR_W != 32) begin
      $error("pasm_map serves 32-bit program addresses only");
    end
  end

  // ****************************************************************
  // segment decode
  // ****************************************************************
  pasm_seg_decode #(
    .HAS_RESERVED_TOP (HAS_RESERVED_TOP)
  ) u_dec (
    .prog_addr (prog_addr),
    .seg       (seg)
  );

  // ****************************************************************
  // privilege mode
  // ****************************************************************
  // kernel on reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      user_mode <= 1'b0;
    end else if (mode_to_kernel) begin
      // kernel entry from a trap beats a return to user
      user_mode <= 1'b0;
    end else if (mode_to_user) begin
      user_mode <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reset_fetch_addr <= `PASM_RESET_VECTOR;
    end else begin
      reset_fetch_addr <= `PASM_RESET_VECTOR;
    end
  end

  // ****************************************************************
  // translation and attributes
  // ****************************************************************
  logic use_xlat;
  logic priv_error;

  always_comb begin
    use_xlat  = 1'b0;
    phys_addr = prog_addr;
    cacheable = 1'b0;
    unique case (seg)
      PASM_SEG_USER: begin
        if (HAS_XLAT) begin
          use_xlat  = 1'b1;
          phys_addr = xlat_phys_addr;
          cacheable = xlat_cacheable;
        end else begin
          phys_addr = prog_addr + `PASM_USER_OFFSET;
          cacheable = 1'b1;
        end
      end
      PASM_SEG_CACHED_KERNEL: begin
        phys_addr = prog_addr & `PASM_TOP_CLEAR;
        cacheable = 1'b1;
      end
      PASM_SEG_UNCACHED_KERNEL: begin
        phys_addr = prog_addr & `PASM_LOW_MASK;
        cacheable = 1'b0;
      end
      PASM_SEG_UPPER_KERNEL: begin
        if (HAS_XLAT) begin
          use_xlat  = 1'b1;
          phys_addr = xlat_phys_addr;
          cacheable = xlat_cacheable;
        end else begin
          phys_addr = prog_addr;
          cacheable = 1'b1;
        end
      end
      PASM_SEG_RESERVED: begin
        // on-chip register window, uncached and untranslated
        phys_addr = prog_addr;
        cacheable = 1'b0;
      end
      default: begin
        phys_addr = prog_addr;
        cacheable = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // traps and request gating
  // ****************************************************************
  // top bit in user mode
  assign priv_error   = user_mode && prog_addr[`PASM_TOP_BIT];
  assign addr_error   = req_valid && (priv_error || (use_xlat && xlat_fault));

  assign insn_illegal = user_mode &&
                        (insn_privileged || (insn_coproc_access && !coproc_user_enable));

  assign mem_req  = req_valid && !addr_error;
  assign xlat_req = req_valid && use_xlat && !priv_error;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_USER_TRAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req_valid && user_mode && prog_addr[31]) |-> (addr_error && !mem_req))
    else $error("user access to kernel address not trapped");

  AST_USER_OK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req_valid && !prog_addr[31] && !HAS_XLAT) |-> mem_req)
    else $error("legal user-segment access suppressed");

  AST_USER_OFFSET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!HAS_XLAT && !prog_addr[31]) |-> (phys_addr == prog_addr + `PASM_USER_OFFSET))
    else $error("user segment offset wrong");

  AST_CACHED_MAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (prog_addr[31:29] == `PASM_SEG_CACHED) |->
      (phys_addr == {3'H0, prog_addr[28:0]} && cacheable))
    else $error("cached kernel mapping wrong");

  AST_UNCACHED_MAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (prog_addr[31:29] == `PASM_SEG_UNCACHED) |->
      (phys_addr == {3'H0, prog_addr[28:0]} && !cacheable))
    else $error("uncached kernel mapping wrong");

  AST_RESET_VECTOR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reset_fetch_addr & `PASM_LOW_MASK) == `PASM_RESET_PHYS)
    else $error("reset vector not at boot physical address");

  AST_KERNEL_NO_TRAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!user_mode && !use_xlat) |-> !addr_error)
    else $error("kernel mode address trapped");

  AST_RESET_KERNEL: assert property (@(posedge sys_clk)
    !rst_b |=> !user_mode)
    else $error("reset did not enter kernel mode");

  AST_UPPER_PASS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!HAS_XLAT && seg == PASM_SEG_UPPER_KERNEL) |-> (phys_addr == prog_addr))
    else $error("upper kernel segment altered");

  AST_NO_GAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !HAS_XLAT |-> !(phys_addr >= `PASM_GAP_LO && phys_addr <= `PASM_GAP_HI))
    else $error("physical address in gap");

  AST_COPROC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (user_mode && insn_coproc_access && !coproc_user_enable) |-> insn_illegal)
    else $error("withheld coprocessor access not illegal");

  AST_XLAT_ROUTE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (HAS_XLAT && req_valid && !prog_addr[31]) |-> xlat_req)
    else $error("user segment not sent to translation unit");

  AST_MODE_STICK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!mode_to_user && !mode_to_kernel) |=> (user_mode == $past(user_mode)))
    else $error("mode changed without request");

  // ****************************************************************
  // segment, mode and routing checks
  // ****************************************************************
  // upper segment trap
  AST_UPPER_KERNEL_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req_valid && user_mode && prog_addr[31:30] == `PASM_SEG_UPPER) |->
      addr_error)
    else $error("user access to upper kernel segment not trapped");

  AST_ERR_NO_REQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    addr_error |->
      !mem_req)
    else $error("memory request issued with address error");

  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !req_valid |->
      (!mem_req && !addr_error && !xlat_req))
    else $error("request or error without a valid access");

  AST_KERNEL_SAME_MAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!HAS_XLAT && !user_mode && !prog_addr[31]) |->
      (phys_addr == prog_addr + `PASM_USER_OFFSET))
    else $error("kernel view of user segment differs");

  AST_USER_NO_TRAP_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!HAS_XLAT && user_mode && req_valid && !prog_addr[31]) |->
      !addr_error)
    else $error("user segment access trapped in user mode");

  AST_CACHED_ATTR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seg == PASM_SEG_CACHED_KERNEL) |->
      cacheable)
    else $error("cached kernel segment not cacheable");

  AST_UNCACHED_ATTR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seg == PASM_SEG_UNCACHED_KERNEL) |->
      !cacheable)
    else $error("uncached kernel segment cacheable");

  AST_SEG_USER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !prog_addr[31] |->
      (seg == PASM_SEG_USER))
    else $error("low half not decoded as user segment");

  AST_SEG_UPPER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!HAS_RESERVED_TOP && prog_addr[31:30] == `PASM_SEG_UPPER) |->
      (seg == PASM_SEG_UPPER_KERNEL))
    else $error("upper quarter not decoded as upper kernel segment");

  AST_RESERVED_WINDOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (HAS_RESERVED_TOP && prog_addr > `PASM_UPPER_LIMIT) |->
      (seg == PASM_SEG_RESERVED && phys_addr == prog_addr && !cacheable))
    else $error("reserved top window mishandled");

  AST_NO_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !HAS_RESERVED_TOP |->
      (seg != PASM_SEG_RESERVED))
    else $error("reserved window decoded with option off");

  AST_XLAT_UPPER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (HAS_XLAT && req_valid && !user_mode && seg == PASM_SEG_UPPER_KERNEL) |->
      (xlat_req && phys_addr == xlat_phys_addr))
    else $error("upper segment not sent to translation unit");

  AST_NO_XLAT_BASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !HAS_XLAT |->
      !xlat_req)
    else $error("translation request in base variant");

  AST_XLAT_FAULT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (xlat_req && xlat_fault) |->
      addr_error)
    else $error("translation fault not reported");

  AST_MODE_TO_USER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mode_to_user && !mode_to_kernel) |=>
      user_mode)
    else $error("user entry request ignored");

  AST_MODE_TO_KERNEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_to_kernel |=>
      !user_mode)
    else $error("kernel entry request ignored");

  AST_INSN_KERNEL_OK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !user_mode |->
      !insn_illegal)
    else $error("instruction illegal in kernel mode");

  AST_INSN_PRIV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (user_mode && insn_privileged) |->
      insn_illegal)
    else $error("privileged instruction allowed in user mode");

  AST_VECTOR_CONST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |->
      (reset_fetch_addr == `PASM_RESET_VECTOR))
    else $error("reset fetch address moved");

  // user range 1 to 3 Gbytes
  AST_USER_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!HAS_XLAT && seg == PASM_SEG_USER) |->
      (phys_addr[31:30] == 2'H1 || phys_addr[31:30] == 2'H2))
    else $error("user physical address outside 1 to 3 Gbytes");
endmodule

// >>> pasm_pkg.sv
package pasm_pkg;
  typedef enum logic [2:0] {
    PASM_SEG_USER,
    PASM_SEG_CACHED_KERNEL,
    PASM_SEG_UNCACHED_KERNEL,
    PASM_SEG_UPPER_KERNEL,
    PASM_SEG_RESERVED
  } pasm_seg_t;
endpackage

// >>> pasm_seg_decode.sv
`timescale 1ns/100ps
`include "pasm_consts.svh"

module pasm_seg_decode
  import pasm_pkg::*;
#(
  parameter bit HAS_RESERVED_TOP = 1'b0
) (
  input  wire logic [31:0]        prog_addr,
  output pasm_pkg::pasm_seg_t     seg
);
  import pasm_pkg::*;

  always_comb begin
    if (prog_addr[31] == `PASM_SEG_USER_MSB) begin
      seg = PASM_SEG_USER;
    end else if (prog_addr[31:29] == `PASM_SEG_CACHED) begin
      seg = PASM_SEG_CACHED_KERNEL;
    end else if (prog_addr[31:29] == `PASM_SEG_UNCACHED) begin
      seg = PASM_SEG_UNCACHED_KERNEL;
    end else if (HAS_RESERVED_TOP && (prog_addr > `PASM_UPPER_LIMIT)) begin
      // top 16 Mbytes left for on-chip registers and emulator
      seg = PASM_SEG_RESERVED;
    end else begin
      seg = PASM_SEG_UPPER_KERNEL;
    end
  end
endmodule

// >>> pasm_xlat_model.sv
`timescale 1ns/100ps
// ****************************************************************
// translation unit stand-in
// ****************************************************************
module pasm_xlat_model (
  input  wire logic        sys_clk,
  input  wire logic        xlat_req,
  input  wire logic [31:0] prog_addr,
  output logic [31:0]      xlat_phys_addr,
  output logic             xlat_cacheable,
  output logic             xlat_fault
);
  // idle answer is scrambled so a stale value cannot pass as valid
  always_comb begin
    xlat_phys_addr = xlat_req ? {4'H0, prog_addr[27:0]} : ~prog_addr;
    xlat_cacheable = xlat_req ? 1'b1 : sys_clk;
    xlat_fault     = xlat_req ? 1'b0 : ~sys_clk;
  end
endmodule

// >>> program_address_segment_map_tb_top.sv
`timescale 1ns/100ps
module program_address_segment_map_tb_top;
  import pasm_pkg::*;
  logic        sys_clk, rst_b, req_valid, mode_to_user, mode_to_kernel;
  logic        insn_privileged, insn_coproc_access, coproc_user_enable;
  logic        xlat_cacheable, xlat_fault, user_mode, cacheable;
  logic        addr_error, insn_illegal, mem_req, xlat_req;
  logic [31:0] prog_addr, xlat_phys_addr, reset_fetch_addr, phys_addr;
  pasm_seg_t   seg;
  int          n_errors = 0;
  int          n_tests = 0;

  pasm_map DUT (.sys_clk(sys_clk), .rst_b(rst_b), .prog_addr(prog_addr),
    .req_valid(req_valid), .mode_to_user(mode_to_user), .mode_to_kernel(mode_to_kernel),
    .insn_privileged(insn_privileged), .insn_coproc_access(insn_coproc_access),
    .coproc_user_enable(coproc_user_enable), .xlat_phys_addr(xlat_phys_addr),
    .xlat_cacheable(xlat_cacheable), .xlat_fault(xlat_fault), .user_mode(user_mode),
    .reset_fetch_addr(reset_fetch_addr), .phys_addr(phys_addr), .cacheable(cacheable),
    .addr_error(addr_error), .insn_illegal(insn_illegal), .mem_req(mem_req),
    .xlat_req(xlat_req), .seg(seg));
  pasm_xlat_model XLAT (.sys_clk(sys_clk), .xlat_req(xlat_req), .prog_addr(prog_addr),
    .xlat_phys_addr(xlat_phys_addr), .xlat_cacheable(xlat_cacheable),
    .xlat_fault(xlat_fault));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'H0, got}, {31'H0, exp});
  endtask
  // inputs move on the falling edge, outputs read mid low phase
  task automatic drive(input logic [31:0] a, input logic v);
    @(negedge sys_clk);
    prog_addr = a;
    req_valid = v;
    #20;
  endtask
  task automatic set_mode(input logic u, input logic k);
    @(negedge sys_clk);
    mode_to_user = u;
    mode_to_kernel = k;
    @(negedge sys_clk);
    mode_to_user = 1'b0;
    mode_to_kernel = 1'b0;
  endtask
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk1(user_mode, 1'b0);
    chk32(reset_fetch_addr, 32'HBFC0_0000);
    drive(32'HBFC0_0000, 1'b1);
    chk32(phys_addr, 32'H1FC0_0000);
    chk1(cacheable, 1'b0);
    $display("t_reset done");
  endtask
  task automatic t_kernel_map;
    logic [31:0] a [7] = '{32'H0000_1000, 32'H7FFF_FFFF, 32'H8000_0000, 32'H9FFF_FFFC,
                           32'HA000_1000, 32'HC000_0000, 32'HFFFF_FFFF};
    logic [31:0] p [7] = '{32'H4000_1000, 32'HBFFF_FFFF, 32'H0000_0000, 32'H1FFF_FFFC,
                           32'H0000_1000, 32'HC000_0000, 32'HFFFF_FFFF};
    logic        c [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    pasm_seg_t   s [7] = '{PASM_SEG_USER, PASM_SEG_USER, PASM_SEG_CACHED_KERNEL,
                           PASM_SEG_CACHED_KERNEL, PASM_SEG_UNCACHED_KERNEL,
                           PASM_SEG_UPPER_KERNEL, PASM_SEG_UPPER_KERNEL};
    for (int i = 0; i < 7; i++) begin
      drive(a[i], 1'b1);
      chk32(phys_addr, p[i]);
      chk1(cacheable, c[i]);
      chk1(addr_error, 1'b0);
      chk1(mem_req, 1'b1);
      chk1(phys_addr[31:29] == 3'H1, 1'b0);
      chk32({29'H0, seg}, {29'H0, s[i]});
      chk1(xlat_req, 1'b0);
    end
    $display("t_kernel_map done");
  endtask
  task automatic t_user;
    logic [31:0] bad [5] = '{32'H8000_0000, 32'H9FFF_FFFF, 32'HA000_0000,
                             32'HC000_0000, 32'HFFFF_FFFF};
    set_mode(1'b1, 1'b0);
    chk1(user_mode, 1'b1);
    drive(32'H0000_1000, 1'b1);
    chk32(phys_addr, 32'H4000_1000);
    drive(32'H7FFF_FFFF, 1'b1);
    chk1(addr_error, 1'b0);
    chk1(mem_req, 1'b1);
    for (int i = 0; i < 5; i++) begin
      drive(bad[i], 1'b1);
      chk1(addr_error, 1'b1);
      chk1(mem_req, 1'b0);
    end
    drive(32'H8000_0000, 1'b0);
    chk1(mem_req, 1'b0);
    $display("t_user done");
  endtask
  task automatic t_insn;
    logic [2:0] v;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        v = i[2:0];
        @(negedge sys_clk);
        {insn_privileged, insn_coproc_access, coproc_user_enable} = v;
        #20;
        chk1(insn_illegal, m == 0 && (v[2] || (v[1] && !v[0])));
      end
      // kernel entry outranks user entry
      set_mode(1'b1, 1'b1);
      chk1(user_mode, 1'b0);
    end
    $display("t_insn done");
  endtask
  // reset in mid-run from user mode must land back in kernel mode
  task automatic t_rerun;
    set_mode(1'b1, 1'b0);
    chk1(user_mode, 1'b1);
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    chk1(user_mode, 1'b0);
    chk32(reset_fetch_addr, 32'HBFC0_0000);
    drive(32'H8000_0000, 1'b1);
    chk1(addr_error, 1'b0);
    $display("t_rerun done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    {rst_b, req_valid, mode_to_user, mode_to_kernel} = 4'H0;
    {insn_privileged, insn_coproc_access, coproc_user_enable} = 3'H0;
    prog_addr = 32'H0000_0000;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_kernel_map();
    t_user();
    t_insn();
    t_rerun();
    stop_test();
  end
endmodule
